// ==== hdl/ppfm_cfg.svh ====
// Functional notes
// - The single-bit port pin also feeds external interrupt five and the stop-mode release input.
// - Port 4 is an eight-bit tri-state port with per-bit direction, all bits input during reset.
// - Display red, green, blue and focus/blank go to port 6 bits 7..4 only where the selection bit at F91 is one.
// - The reset pin is two-way: it takes an external reset and drives out watchdog, trap and clock resets.
`ifndef PPFM_CFG_SVH
`define PPFM_CFG_SVH

// Register offsets on the 12-bit register port.
`define PPFM_OFS_P2 12'hF82
`define PPFM_OFS_P3 12'hF83
`define PPFM_OFS_P4 12'hF84
`define PPFM_OFS_P5 12'hF85
`define PPFM_OFS_P6 12'hF86
`define PPFM_OFS_P7 12'hF87
`define PPFM_OFS_P4DIR 12'hF8A
`define PPFM_OFS_P6DIR 12'hF8B
`define PPFM_OFS_SEL 12'hF91
`define PPFM_OFS_CAUSE 12'hF92

// Reset values.
`define PPFM_RST_LATCH 8'hFF
`define PPFM_RST_DIR 8'h00
`define PPFM_RST_SEL 8'h00

// Field positions.
`define PPFM_SEL_LSB 4
`define PPFM_CAUSE_EXT 0
`define PPFM_CAUSE_WDT 1
`define PPFM_CAUSE_TRAP 2
`define PPFM_CAUSE_CLK 3

`endif

// ==== hdl/ppfm_pkg.sv ====
`default_nettype none
package ppfm_pkg;
    typedef logic [7:0] ppfm_byte_t;
    typedef logic [11:0] ppfm_addr_t;
    typedef logic [3:0] ppfm_cause_t;
endpackage : ppfm_pkg
`default_nettype wire

// ==== hdl/ppfm_rst_if.sv ====
`default_nettype none
interface ppfm_rst_if;
    import ppfm_pkg::*;
    logic pin_in;
    logic pin_oe;
    logic wdt_req;
    logic trap_req;
    logic clk_req;
    logic sys_reset;
    ppfm_cause_t cause;
    ppfm_cause_t clear;
    modport ctl (input pin_in, wdt_req, trap_req, clk_req, clear, output pin_oe, sys_reset, cause);
    modport user (output pin_in, wdt_req, trap_req, clk_req, clear, input pin_oe, sys_reset, cause);
endinterface : ppfm_rst_if
`default_nettype wire

// ==== hdl/ppfm_reset_pin.sv ====
`include "ppfm_cfg.svh"
`default_nettype none
module ppfm_reset_pin (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Reset pin side and causes.
    ppfm_rst_if.ctl rif
);
    import ppfm_pkg::*;

    logic drive;
    ppfm_cause_t next_cause;
    ppfm_cause_t cause_set;
    wire internal_req = rif.wdt_req | rif.trap_req | rif.clk_req;
    // Our own drive also pulls the pin low, so an external cause needs the pin low while we are quiet.
    wire ext_low = ~rif.pin_in & ~drive;

    // A set arriving in the clear cycle wins so no cause is lost.
    assign cause_set = {rif.clk_req, rif.trap_req, rif.wdt_req, ext_low};
    assign next_cause = (rif.cause & ~rif.clear) | cause_set;
    assign rif.pin_oe = drive;

    // Internal reset requests pull the pin low one cycle later.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive <= 1'b0;
            rif.sys_reset <= 1'b0;
            rif.cause <= '0;
        end else begin
            drive <= internal_req;
            rif.sys_reset <= ~rif.pin_in | internal_req;
            rif.cause <= next_cause;
        end
    end
endmodule : ppfm_reset_pin
`default_nettype wire

// ==== hdl/ppfm_port_top.sv ====
`include "ppfm_cfg.svh"
`default_nettype none
module ppfm_port_top #(
    parameter int ADDR_W = 12
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // Register port.
    input wire ppfm_pkg::ppfm_addr_t ADDR,
    input wire ppfm_pkg::ppfm_byte_t WDATA,
    input wire logic WR,
    input wire logic RD,
    output var ppfm_pkg::ppfm_byte_t RDATA,
    // Single-bit port pin.
    input wire logic P2_IN,
    output logic P2_OUT,
    output logic P2_OE,
    // Port 3 pins.
    input wire logic [6:0] P3_IN,
    output logic [6:0] P3_OUT,
    output logic [6:0] P3_OE,
    // Port 4 pins.
    input wire ppfm_pkg::ppfm_byte_t P4_IN,
    output logic [7:0] P4_OUT,
    output logic [7:0] P4_OE,
    // Port 5 pins.
    input wire ppfm_pkg::ppfm_byte_t P5_IN,
    output logic [7:0] P5_OUT,
    output logic [7:0] P5_OE,
    // Port 6 pins.
    input wire ppfm_pkg::ppfm_byte_t P6_IN,
    output logic [7:0] P6_OUT,
    output logic [7:0] P6_OE,
    // Port 7 pins.
    input wire logic [1:0] P7_IN,
    output logic [1:0] P7_OUT,
    output logic [1:0] P7_OE,
    // Reset pin.
    input wire logic RESET_PIN_IN,
    output logic RESET_PIN_OUT,
    output logic RESET_PIN_OE,
    // Internal reset causes and the resulting system reset.
    input wire logic WDT_RESET_REQ,
    input wire logic TRAP_RESET_REQ,
    input wire logic CLK_RESET_REQ,
    output logic SYS_RESET,
    // Alternate outputs from peripherals.
    input wire logic SER_SCK_OUT,
    input wire logic SER_SDA_OUT,
    input wire logic SER_SCL_OUT,
    input wire ppfm_pkg::ppfm_byte_t PWM_DA_OUTPUT,
    input wire logic [1:0] PWM_DA_HIGH_OUTPUT,
    input wire logic PLL_PULSE_OUTPUT,
    input wire logic OSD_RED,
    input wire logic OSD_GREEN,
    input wire logic OSD_BLUE,
    input wire logic FOCUS_BLANK_OUTPUT,
    // Alternate inputs to peripherals.
    output logic EXT_IRQ_FIVE,
    output logic STOP_RELEASE,
    output logic EXT_IRQ_THREE,
    output logic REMOTE_CTRL_INPUT,
    output logic COUNTER_THREE_INPUT,
    output logic EXT_IRQ_FOUR,
    output logic COUNTER_FOUR_INPUT,
    output logic SER_SCL_IN,
    output logic SER_SDA_IN,
    output logic SER_SCK_IN,
    output logic [3:0] COMPARATOR_INPUT,
    output logic VERTICAL_SYNC_INPUT,
    output logic HORIZONTAL_SYNC_INPUT
);
    import ppfm_pkg::*;

    // The decoders compare full 12-bit offsets, so no other address width can be served.
    if (ADDR_W != 12) begin : g_addr_w_check
        $error("ppfm_port_top: ADDR_W must be 12");
    end

    // Address hit test, shared by the write and read decoders.
    function automatic logic hit(input ppfm_addr_t a, input ppfm_addr_t ofs);
        hit = (a == ofs);
    endfunction : hit

    logic p2_latch;
    logic [6:0] p3_latch;
    ppfm_byte_t p4_data;
    ppfm_byte_t p4_dir;
    ppfm_byte_t p5_latch;
    ppfm_byte_t p6_data;
    ppfm_byte_t p6_dir;
    logic [1:0] p7_latch;
    ppfm_byte_t port6_display_output_select;
    ppfm_byte_t next_rdata;
    logic [19:4] alt_in;

    // Write decode.
    wire wr_p2 = WR & hit(ADDR, `PPFM_OFS_P2);
    wire wr_p3 = WR & hit(ADDR, `PPFM_OFS_P3);
    wire wr_p4 = WR & hit(ADDR, `PPFM_OFS_P4);
    wire wr_p5 = WR & hit(ADDR, `PPFM_OFS_P5);
    wire wr_p6 = WR & hit(ADDR, `PPFM_OFS_P6);
    wire wr_p7 = WR & hit(ADDR, `PPFM_OFS_P7);
    wire wr_p4dir = WR & hit(ADDR, `PPFM_OFS_P4DIR);
    wire wr_p6dir = WR & hit(ADDR, `PPFM_OFS_P6DIR);
    wire wr_sel = WR & hit(ADDR, `PPFM_OFS_SEL);
    wire wr_cause = WR & hit(ADDR, `PPFM_OFS_CAUSE);

    // Reset pin logic lives in its own module behind an interface.
    ppfm_rst_if rif ();
    assign rif.pin_in = RESET_PIN_IN;
    assign rif.wdt_req = WDT_RESET_REQ;
    assign rif.trap_req = TRAP_RESET_REQ;
    assign rif.clk_req = CLK_RESET_REQ;
    assign rif.clear = wr_cause ? WDATA[3:0] : 4'h0;
    ppfm_reset_pin u_reset_pin (
        .clk (CLK),
        .rst (RST),
        .rif (rif)
    );
    assign RESET_PIN_OUT = 1'b0;
    assign RESET_PIN_OE = rif.pin_oe;
    assign SYS_RESET = rif.sys_reset;

    // Latched ports sink only: a zero latch or a low alternate output pulls the pin low, a one releases it.
    // Alternate outputs are ANDed with the latch, so software must leave the latch at one to use them.
    assign P2_OUT = 1'b0;
    assign P2_OE = ~p2_latch;
    assign P3_OUT = 7'h00;
    assign P3_OE = ~(p3_latch & {SER_SCK_OUT, SER_SDA_OUT, SER_SCL_OUT, 4'hF});
    assign P5_OUT = 8'h00;
    assign P5_OE = ~(p5_latch & {5'h1F, PLL_PULSE_OUTPUT, PWM_DA_HIGH_OUTPUT});
    assign P7_OUT = 2'h0;
    assign P7_OE = ~p7_latch;

    // Port 4 is push-pull under its direction bits; the latch gates the pulse-width signal.
    assign P4_OUT = p4_data & PWM_DA_OUTPUT;
    assign P4_OE = p4_dir;

    // Port 6 upper half takes display signals where selected; a selected bit drives even if its
    // direction is input, since the display needs the pin regardless of software's port use.
    wire [3:0] osd_sel = port6_display_output_select[`PPFM_SEL_LSB +: 4];
    wire [3:0] osd_sig = {FOCUS_BLANK_OUTPUT, OSD_BLUE, OSD_GREEN, OSD_RED};
    assign P6_OUT = {(osd_sel & osd_sig) | (~osd_sel & p6_data[7:4]), p6_data[3:0]};
    assign P6_OE = {p6_dir[7:4] | osd_sel, p6_dir[3:0]};

    // Read mux: port addresses return the pin levels, control registers read back.
    assign next_rdata =
        !RD ? 8'h00 :
        hit(ADDR, `PPFM_OFS_P2) ? {7'h00, P2_IN} :
        hit(ADDR, `PPFM_OFS_P3) ? {1'b0, P3_IN} :
        hit(ADDR, `PPFM_OFS_P4) ? P4_IN :
        hit(ADDR, `PPFM_OFS_P5) ? P5_IN :
        hit(ADDR, `PPFM_OFS_P6) ? P6_IN :
        hit(ADDR, `PPFM_OFS_P7) ? {6'h00, P7_IN} :
        hit(ADDR, `PPFM_OFS_P4DIR) ? p4_dir :
        hit(ADDR, `PPFM_OFS_P6DIR) ? p6_dir :
        hit(ADDR, `PPFM_OFS_SEL) ? port6_display_output_select :
        hit(ADDR, `PPFM_OFS_CAUSE) ? {4'h0, rif.cause} :
        8'h00;

    // Alternate-function inputs taken straight from the pin levels.
    assign alt_in = {P2_IN, P2_IN, P3_IN[0], P3_IN[0], P3_IN[1], P3_IN[2], P3_IN[3],
                     P3_IN[4], P3_IN[5], P3_IN[6], P5_IN[7:4], P7_IN[1], P7_IN[0]};

    // Peripheral inputs are registered once so every peripheral input comes from a flip-flop.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            {EXT_IRQ_FIVE, STOP_RELEASE, EXT_IRQ_THREE, REMOTE_CTRL_INPUT} <= 4'hF;
            {COUNTER_THREE_INPUT, EXT_IRQ_FOUR, COUNTER_FOUR_INPUT} <= 3'h7;
            {SER_SCL_IN, SER_SDA_IN, SER_SCK_IN} <= 3'h7;
            COMPARATOR_INPUT <= 4'h0;
            {VERTICAL_SYNC_INPUT, HORIZONTAL_SYNC_INPUT} <= 2'h3;
        end else begin
            {EXT_IRQ_FIVE, STOP_RELEASE} <= alt_in[19:18];
            {EXT_IRQ_THREE, REMOTE_CTRL_INPUT} <= alt_in[17:16];
            {COUNTER_THREE_INPUT, EXT_IRQ_FOUR, COUNTER_FOUR_INPUT} <= alt_in[15:13];
            {SER_SCL_IN, SER_SDA_IN, SER_SCK_IN} <= alt_in[12:10];
            COMPARATOR_INPUT <= alt_in[9:6];
            {VERTICAL_SYNC_INPUT, HORIZONTAL_SYNC_INPUT} <= alt_in[5:4];
        end
    end

    // Latches, directions and read data.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            p2_latch <= 1'b1;
            p3_latch <= 7'h7F;
            p4_data <= `PPFM_RST_LATCH;
            p5_latch <= `PPFM_RST_LATCH;
            p6_data <= `PPFM_RST_LATCH;
            p7_latch <= 2'h3;
            p4_dir <= `PPFM_RST_DIR;
            p6_dir <= `PPFM_RST_DIR;
            port6_display_output_select <= `PPFM_RST_SEL;
            RDATA <= 8'h00;
        end else begin
            if (wr_p2) p2_latch <= WDATA[0];
            if (wr_p3) p3_latch <= WDATA[6:0];
            if (wr_p4) p4_data <= WDATA;
            if (wr_p5) p5_latch <= WDATA;
            if (wr_p6) p6_data <= WDATA;
            if (wr_p7) p7_latch <= WDATA[1:0];
            if (wr_p4dir) p4_dir <= WDATA;
            if (wr_p6dir) p6_dir <= WDATA;
            if (wr_sel) port6_display_output_select <= WDATA;
            RDATA <= next_rdata;
        end
    end

    // Register writes, reset state and display routing.
    AST_P4_DIR_WRITE: assert property (@(posedge CLK) disable iff (RST)
        wr_p4dir |=> (P4_OE == $past(WDATA)))
        else $error("port 4 direction did not follow write");
    AST_P4_LATCH_BLOCKS_PWM: assert property (@(posedge CLK) disable iff (RST)
        (p4_data == 8'h00) |-> (P4_OUT == 8'h00))
        else $error("pulse-width output passed a zero latch");
    AST_PORTS_INPUT_AFTER_RESET: assert property (@(posedge CLK) disable iff (RST)
        $past(RST) |-> (P6_OE == 8'h00 && P4_OE == 8'h00))
        else $error("port driven right after reset");
    AST_P6_ROUTE_FOCUS: assert property (@(posedge CLK) disable iff (RST)
        ##1 $past(wr_sel && WDATA[7]) |-> (P6_OUT[7] == FOCUS_BLANK_OUTPUT && P6_OE[7]))
        else $error("focus/blank not routed to port 6 bit 7");
    AST_P6_NO_ROUTE: assert property (@(posedge CLK) disable iff (RST)
        (osd_sel == 4'h0) |-> (P6_OUT == p6_data && P6_OE == p6_dir))
        else $error("display signal leaked onto port 6");
    AST_IRQ5_FOLLOWS_PIN: assert property (@(posedge CLK) disable iff (RST)
        ##1 (EXT_IRQ_FIVE == $past(P2_IN) && STOP_RELEASE == $past(P2_IN)))
        else $error("interrupt five or stop release not following pin");
    AST_LATCH_ZERO_PULLS: assert property (@(posedge CLK) disable iff (RST)
        wr_p3 && !WDATA[0] |=> (P3_OE[0] && !P3_OUT[0]))
        else $error("latched pin with zero latch not pulled low");
    AST_PIN_READ: assert property (@(posedge CLK) disable iff (RST)
        RD && hit(ADDR, `PPFM_OFS_P2) |=> (RDATA == {7'h00, $past(P2_IN)}))
        else $error("pin read did not return outside level");
    AST_RESET_DRIVE_OUT: assert property (@(posedge CLK) disable iff (RST)
        (WDT_RESET_REQ || TRAP_RESET_REQ || CLK_RESET_REQ) |=> (RESET_PIN_OE && SYS_RESET))
        else $error("internal reset not driven onto reset pin");
    AST_EXT_RESET_IN: assert property (@(posedge CLK) disable iff (RST)
        !RESET_PIN_IN |=> SYS_RESET)
        else $error("external reset not accepted");

    // Sink ports: a pin is pulled low by a zero latch or a low alternate output, and never driven high.
    AST_P2_SINK_ONLY: assert property (@(posedge CLK) disable iff (RST)
        wr_p2 |=> (P2_OE == !$past(WDATA[0]) && !P2_OUT))
        else $error("single-bit port pin does not follow its latch");
    AST_P3_SDA_PULL: assert property (@(posedge CLK) disable iff (RST)
        !SER_SDA_OUT |-> P3_OE[5])
        else $error("low serial data output not pulled onto port 3");
    AST_P5_PLL_PULL: assert property (@(posedge CLK) disable iff (RST)
        !PLL_PULSE_OUTPUT |-> P5_OE[2])
        else $error("low pulse output not pulled onto port 5");
    AST_P5_LATCH_WRITE: assert property (@(posedge CLK) disable iff (RST)
        wr_p5 |=> (P5_OE[7:3] == ~$past(WDATA[7:3])))
        else $error("port 5 pins do not follow their latch");
    AST_P7_LATCH_WRITE: assert property (@(posedge CLK) disable iff (RST)
        wr_p7 |=> (P7_OE == ~$past(WDATA[1:0])))
        else $error("port 7 pins do not follow their latch");

    // Tri-state ports: direction and data are separate, and the display takes only selected bits.
    AST_P4_PWM_PASSES: assert property (@(posedge CLK) disable iff (RST)
        (p4_data == 8'hFF) |-> (P4_OUT == PWM_DA_OUTPUT))
        else $error("pulse-width output blocked by a set latch");
    AST_P4_DIR_NOT_DATA: assert property (@(posedge CLK) disable iff (RST)
        wr_p4 |=> (P4_OE == $past(P4_OE)))
        else $error("port 4 data write changed its direction");
    AST_P6_ROUTE_GREEN: assert property (@(posedge CLK) disable iff (RST)
        port6_display_output_select[5] |-> (P6_OUT[5] == OSD_GREEN && P6_OE[5]))
        else $error("green not routed to port 6 bit 5");
    AST_P6_LOWER_DIR: assert property (@(posedge CLK) disable iff (RST)
        wr_p6dir |=> (P6_OE[3:0] == $past(WDATA[3:0])))
        else $error("port 6 lower direction did not follow write");
    AST_P6_LOWER_DATA: assert property (@(posedge CLK) disable iff (RST)
        wr_p6 |=> (P6_OUT[3:0] == $past(WDATA[3:0])))
        else $error("port 6 lower data did not follow write");

    // Alternate inputs are the pin levels one cycle late.
    AST_IRQ4_FOLLOWS_PIN: assert property (@(posedge CLK) disable iff (RST)
        1'b1 |=> (EXT_IRQ_FOUR == $past(P3_IN[2]) && COUNTER_THREE_INPUT == $past(P3_IN[1])))
        else $error("port 3 interrupt or counter input not following pin");
    AST_SERIAL_IN_FOLLOWS_PIN: assert property (@(posedge CLK) disable iff (RST)
        1'b1 |=> ({SER_SCK_IN, SER_SDA_IN, SER_SCL_IN} == $past(P3_IN[6:4])))
        else $error("serial inputs not following port 3 pins");
    AST_COMPARATOR_FOLLOWS_PIN: assert property (@(posedge CLK) disable iff (RST)
        1'b1 |=> (COMPARATOR_INPUT == $past(P5_IN[7:4])))
        else $error("comparator inputs not following port 5 pins");
    AST_SYNC_FOLLOWS_PIN: assert property (@(posedge CLK) disable iff (RST)
        1'b1 |=> ({VERTICAL_SYNC_INPUT, HORIZONTAL_SYNC_INPUT} == $past(P7_IN)))
        else $error("sync inputs not following port 7 pins");

    // Reset pin: the drive stops with the request, and each internal cause is recorded.
    AST_RESET_PIN_RELEASE: assert property (@(posedge CLK) disable iff (RST)
        !(WDT_RESET_REQ || TRAP_RESET_REQ || CLK_RESET_REQ) |=> !RESET_PIN_OE)
        else $error("reset pin still driven without a request");
    AST_RESET_CAUSE_WDT: assert property (@(posedge CLK) disable iff (RST)
        WDT_RESET_REQ |=> rif.cause[`PPFM_CAUSE_WDT])
        else $error("watchdog reset cause not recorded");
    AST_RESET_CAUSE_TRAP: assert property (@(posedge CLK) disable iff (RST)
        TRAP_RESET_REQ |=> rif.cause[`PPFM_CAUSE_TRAP])
        else $error("address trap reset cause not recorded");
    AST_RESET_CAUSE_CLK: assert property (@(posedge CLK) disable iff (RST)
        CLK_RESET_REQ |=> rif.cause[`PPFM_CAUSE_CLK])
        else $error("system clock reset cause not recorded");
endmodule : ppfm_port_top
`default_nettype wire

// ==== test/ppfm_board.sv ====
`default_nettype none
// Board around the pins: the board level on sink lines the device releases, and on tri-state lines left as inputs.
module ppfm_board (
    // Device drive.
    input wire logic p2_oe,
    input wire logic [6:0] p3_oe,
    input wire ppfm_pkg::ppfm_byte_t p4_out,
    input wire ppfm_pkg::ppfm_byte_t p4_oe,
    input wire ppfm_pkg::ppfm_byte_t p5_oe,
    input wire ppfm_pkg::ppfm_byte_t p6_out,
    input wire ppfm_pkg::ppfm_byte_t p6_oe,
    input wire logic [1:0] p7_oe,
    input wire logic rst_oe,
    // Levels the board applies.
    input wire ppfm_pkg::ppfm_byte_t drv,
    input wire logic rst_drv_n,
    // Resolved pin levels.
    output logic p2,
    output logic [6:0] p3,
    output logic [7:0] p4,
    output logic [7:0] p5,
    output logic [7:0] p6,
    output logic [1:0] p7,
    output logic rst_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    import ppfm_pkg::*;
    // A sink pin pulled by the device reads low whatever the board does, so an input needs its latch at one.
    assign p2 = drv[0] & ~p2_oe;
    assign p3 = drv[6:0] & ~p3_oe;
    assign p5 = drv & ~p5_oe;
    assign p7 = drv[1:0] & ~p7_oe;
    // Tri-state lines show the device level where enabled and the board level elsewhere.
    assign p4 = (p4_out & p4_oe) | (drv & ~p4_oe);
    assign p6 = (p6_out & p6_oe) | (drv & ~p6_oe);
    // The reset line has a pull-up and is low while either side pulls it.
    assign rst_pin = rst_drv_n & ~rst_oe;
endmodule : ppfm_board
`default_nettype wire

// ==== test/tb_top.sv ====
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ppfm_pkg::*;
    // Stimulus and observed signals.
    logic clk = 1'b0;
    logic rst = 1'b1;
    ppfm_addr_t addr = 12'h000;
    ppfm_byte_t wdata = 8'h00;
    logic wstb = 1'b0;
    logic rstb = 1'b0;
    ppfm_byte_t drv = 8'hFF;
    ppfm_byte_t alt = 8'hFF;
    ppfm_byte_t pwm = 8'h00;
    logic [2:0] req = 3'h0;
    logic rst_drv_n = 1'b1;
    ppfm_byte_t rdata, p4_in, p4_out, p4_oe, p5_in, p5_oe, p6_in, p6_out, p6_oe;
    logic p2_in, p2_oe, rpin_in, rpin_oe, sys_rst;
    logic [6:0] p3_in, p3_oe;
    logic [1:0] p7_in, p7_oe;
    wire [15:0] ai;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    // Peripheral outputs share the alt byte, except the pulse-width byte on pwm, so no input is tied.
    ppfm_port_top i_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wstb), .RD(rstb), .RDATA(rdata),
        .P2_IN(p2_in), .P2_OUT(), .P2_OE(p2_oe), .P3_IN(p3_in), .P3_OUT(), .P3_OE(p3_oe),
        .P4_IN(p4_in), .P4_OUT(p4_out), .P4_OE(p4_oe), .P5_IN(p5_in), .P5_OUT(), .P5_OE(p5_oe),
        .P6_IN(p6_in), .P6_OUT(p6_out), .P6_OE(p6_oe), .P7_IN(p7_in), .P7_OUT(), .P7_OE(p7_oe),
        .RESET_PIN_IN(rpin_in), .RESET_PIN_OUT(), .RESET_PIN_OE(rpin_oe), .WDT_RESET_REQ(req[0]),
        .TRAP_RESET_REQ(req[1]), .CLK_RESET_REQ(req[2]), .SYS_RESET(sys_rst), .SER_SCK_OUT(alt[6]),
        .SER_SDA_OUT(alt[5]), .SER_SCL_OUT(alt[4]), .PWM_DA_OUTPUT(pwm), .PWM_DA_HIGH_OUTPUT(alt[1:0]),
        .PLL_PULSE_OUTPUT(alt[2]), .OSD_RED(alt[4]), .OSD_GREEN(alt[5]), .OSD_BLUE(alt[6]),
        .FOCUS_BLANK_OUTPUT(alt[7]), .EXT_IRQ_FIVE(ai[15]), .STOP_RELEASE(ai[14]), .EXT_IRQ_THREE(ai[13]),
        .REMOTE_CTRL_INPUT(ai[12]), .COUNTER_THREE_INPUT(ai[11]), .EXT_IRQ_FOUR(ai[10]),
        .COUNTER_FOUR_INPUT(ai[9]), .SER_SCL_IN(ai[8]), .SER_SDA_IN(ai[7]), .SER_SCK_IN(ai[6]),
        .COMPARATOR_INPUT(ai[5:2]), .VERTICAL_SYNC_INPUT(ai[1]), .HORIZONTAL_SYNC_INPUT(ai[0]));
    ppfm_board i_board (.p2_oe(p2_oe), .p3_oe(p3_oe), .p4_out(p4_out), .p4_oe(p4_oe), .p5_oe(p5_oe),
        .p6_out(p6_out), .p6_oe(p6_oe), .p7_oe(p7_oe), .rst_oe(rpin_oe), .drv(drv), .rst_drv_n(rst_drv_n),
        .p2(p2_in), .p3(p3_in), .p4(p4_in), .p5(p5_in), .p6(p6_in), .p7(p7_in), .rst_pin(rpin_in));
    // Clock and a cycle ceiling well above the hundred or so cycles the scenarios need.
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Bus cycles: strobes last one cycle and read data is taken in the cycle after the strobe.
    task automatic reg_wr(input ppfm_addr_t a, input ppfm_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input ppfm_addr_t a, output ppfm_byte_t d);
        @(posedge clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd
    task automatic t_latch();
        ppfm_byte_t d;
        reg_wr(12'hF82, 8'h00);
        #1;
        chk("p2_oe", 16'h1, p2_oe);
        reg_rd(12'hF82, d);
        chk("p2_low", 8'h00, d);
        reg_wr(12'hF82, 8'hFF);
        reg_rd(12'hF82, d);
        chk("p2_high", 8'h01, d);
    endtask : t_latch
    // A zero latch pulls its pin low, so the pin reads low although the board drives it high.
    task automatic t_sinks();
        ppfm_byte_t d;
        reg_wr(12'hF83, 8'h7E);
        reg_wr(12'hF85, 8'h0F);
        reg_wr(12'hF87, 8'h02);
        #1;
        chk("p3_oe_lat", 7'h01, p3_oe);
        chk("p5_oe_lat", 8'hF0, p5_oe);
        chk("p7_oe_lat", 2'h1, p7_oe);
        reg_rd(12'hF83, d);
        chk("p3_pins_lat", 8'h7E, d);
        reg_rd(12'hF85, d);
        chk("p5_pins_lat", 8'h0F, d);
        reg_rd(12'hF87, d);
        chk("p7_pins_lat", 8'h02, d);
        reg_wr(12'hF83, 8'h7F);
        reg_wr(12'hF85, 8'hFF);
        reg_wr(12'hF87, 8'h03);
    endtask : t_sinks
    // Alternate inputs follow the pins one cycle late; latches are back at one after t_sinks.
    task automatic t_alt_in(input ppfm_byte_t d);
        ppfm_byte_t r;
        logic [15:0] e;
        @(posedge clk);
        drv <= d;
        repeat (2) @(posedge clk);
        #1;
        e = {d[0], d[0], d[0], d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7:4], d[1], d[0]};
        chk("alt_in", e, ai);
        reg_rd(12'hF83, r);
        chk("p3_pins", {1'b0, d[6:0]}, r);
    endtask : t_alt_in
    task automatic t_alt_out();
        @(posedge clk);
        alt <= 8'hDB;
        #1;
        chk("p3_oe", 7'h20, p3_oe);
        chk("p5_oe", 8'h04, p5_oe);
        @(posedge clk);
        alt <= 8'hFF;
    endtask : t_alt_out
    task automatic t_p4();
        ppfm_byte_t d;
        reg_wr(12'hF8A, 8'h0F);
        reg_wr(12'hF84, 8'hFF);
        pwm <= 8'h96;
        #1;
        chk("p4_oe", 8'h0F, p4_oe);
        chk("p4_out", 8'h96, p4_out);
        reg_rd(12'hF84, d);
        chk("p4_pins", (8'h96 & 8'h0F) | (drv & 8'hF0), d);
    endtask : t_p4
    // Selected display bits take over bits 7 and 5 even though their direction says input.
    task automatic t_p6();
        ppfm_byte_t d;
        reg_wr(12'hF8B, 8'h03);
        reg_wr(12'hF86, 8'h05);
        reg_wr(12'hF91, 8'hA0);
        alt <= 8'hA5;
        #1;
        chk("p6_oe", 8'hA3, p6_oe);
        chk("p6_out", 8'hA5, p6_out);
        @(posedge clk);
        alt <= 8'h25;
        #1;
        chk("p6_out_fb", 8'h25, p6_out);
        reg_rd(12'hF91, d);
        chk("select", 8'hA0, d);
        alt <= 8'hFF;
    endtask : t_p6
    task automatic t_rst();
        ppfm_byte_t d;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            if (i < 3) begin
                req <= 3'h1 << i;
            end else begin
                rst_drv_n <= 1'b0;
            end
            @(posedge clk);
            #1;
            chk("rst_oe", (i < 3) ? 16'h1 : 16'h0, rpin_oe);
            chk("sys_rst", 16'h1, sys_rst);
            @(posedge clk);
            req <= 3'h0;
            rst_drv_n <= 1'b1;
            repeat (3) @(posedge clk);
            #1;
            chk("sys_rst_off", 16'h0, sys_rst);
            reg_rd(12'hF92, d);
            chk("cause", (i < 3) ? 8'h02 << i : 8'h01, d);
            reg_wr(12'hF92, 8'hFF);
        end
        reg_rd(12'hF80, d);
        chk("unmapped", 8'h00, d);
    endtask : t_rst
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    // Main sequence, ending with a second reset that must return the direction bits to input.
    initial begin
        repeat (8) @(posedge clk);
        chk("p4_oe_rst", 8'h00, p4_oe);
        chk("p6_oe_rst", 8'h00, p6_oe);
        chk("p3_oe_rst", 7'h00, p3_oe);
        rst <= 1'b0;
        t_latch();
        t_sinks();
        t_alt_in(8'hA5);
        t_alt_in(8'h5A);
        t_alt_out();
        t_p4();
        t_p6();
        t_rst();
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        chk("p4_oe_rerst", 8'h00, p4_oe);
        chk("p6_oe_rerst", 8'h00, p6_oe);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
